// *** hdl/sacs_serial_ctrl.sv ***
// Command parser, conversion sequencer and result shifter of the converter.
// Assumes the host is the serial master; analog codes arrive on the core clock.
// Operation
// R1: Result leaves as two bytes, MSB first.
// R2: Temperature word: two pad, twelve bits, two zeros.
// R3: Voltage word: ten bits, three sub, two zeros.
// R4: Power-up enters shutdown until configured.
// R5: Host sends configuration then conversion byte.
// R6: Strobe low at last bit, high when done.
// R7: Host keeps serial clock low during conversion.
// R8: Temperature 2.2ms, voltage 1.1ms strobe low; code adds 0.1ms wake time outside normal mode.
// R9: First result bit shown at strobe rise.
// R10: Zeros after sixteen result bits.
// R11: Chip select high blocks shifting, not conversion.
// R12: Conversion byte alone reuses old configuration.
// R13: Configuration needs zero tag; mode and reference.
// R14: Conversion needs tag 010; four select bits.
// R15: First one after select falls starts byte.
// R16: Reference bit picks internal; temperature always internal.
// R17: Mode codes: shutdown, standby plus, standby, normal.
// R18: Standby stops converter, clock, buffer, temperature.
// R19: Standby plus keeps reference buffer running.
// R20: Shutdown stops all and clears result; code clears it only when idle, and iref_en follows the reference bit.
// R21: Temperature code is Kelvin, eighth degree steps.
// R22: Supply monitor converts quarter supply voltage.
// R23: Input sampled on rising edge, select low.
// R24: Hunt again after configuration or readout.
// R25: Unknown bytes are dropped without effect.
// R26: Diode codes convert temperature, others voltage.
`default_nettype none
module sacs_serial_ctrl
  import sacs_pkg::*;
#(
  parameter int TEMP_CYC = TEMP_CONV_CYC,
  parameter int VOLT_CYC = VOLT_CONV_CYC,
  parameter int WAKE     = WAKE_CYC
) (
  // Core clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Serial link
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       din,
  output logic            dout,
  output logic            conversion_strobe,
  // Analog side
  input  wire sacs_ana_t  ana,
  output sacs_actl_t      actl
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic is_cfg(input logic [CMD_W-1:0] b);
    return b[CFG_TAG_HI:CFG_TAG_LO] == CFG_TAG; // see R13
  endfunction : is_cfg

  function automatic logic is_conv(input logic [CMD_W-1:0] b);
    return b[CONV_TAG_HI:CONV_TAG_LO] == CONV_TAG; // see R14
  endfunction : is_conv

  function automatic logic is_diode(input logic [3:0] s);
    return s == SEL_INT_DIODE || s == SEL_EXT_DIODE1 || s == SEL_EXT_DIODE2; // see R26
  endfunction : is_diode

  function automatic logic [RES_W-1:0] fmt(input logic t, input sacs_ana_t a);
    // Temperature code is Kelvin at 1/8 degree; see R21
    // Supply monitor code comes from the quarter-supply input; see R22
    if (t)
      return {2'h0, a.temp_code, 2'h0}; // see R2
    return {a.volt_code[9], a.volt_code, a.volt_sub, 2'h0}; // see R3
  endfunction : fmt

  ////////////////////////////////////////////////////////////////////////////
  // Link rising edge: command parser
  sacs_rx_t   rx_r;
  sacs_rx_t   rx_nxt;
  sacs_tx_t   tx_r;
  sacs_tx_t   tx_nxt;
  sacs_core_t core_r;
  sacs_core_t core_nxt;

  logic            link_rst;
  logic            hunt;
  logic [CMD_W-1:0] rx_byte;
  logic            out_done;
  logic            fresh;

  assign link_rst = rx_r.rst_s2;
  // Readout finished since the conversion byte was taken
  assign out_done = (tx_r.cnt == 5'(OUT_BITS)) && (tx_r.seen != rx_r.seen_at_req);

  always_comb begin
    rx_nxt = rx_r;
    rx_nxt.rst_s1 = rst;
    rx_nxt.rst_s2 = rx_r.rst_s1;
    rx_byte = {rx_r.shreg, din};
    hunt = 1'b0;
    if (!cs_n) begin // see R23 see R11
      hunt = rx_r.cs_prev || rx_r.state == P_HUNT ||
             (rx_r.state == P_WAIT_OUT && out_done); // see R24
      if (hunt) begin
        rx_nxt.state = P_HUNT;
        if (din) begin // see R15
          rx_nxt.state = P_SHIFT;
          rx_nxt.shreg = 7'h01;
          rx_nxt.bitcnt = 3'h0;
        end
      end else if (rx_r.state == P_SHIFT) begin
        rx_nxt.shreg = rx_byte[6:0];
        rx_nxt.bitcnt = rx_r.bitcnt + 3'h1;
        if (rx_r.bitcnt == 3'h6) begin
          rx_nxt.state = P_HUNT; // see R25
          if (is_cfg(rx_byte) || is_conv(rx_byte)) begin
            rx_nxt.cmd_byte = rx_byte;
            rx_nxt.cmd_tog = ~rx_r.cmd_tog;
          end
          if (!is_cfg(rx_byte) && is_conv(rx_byte)) begin
            rx_nxt.state = P_WAIT_OUT;
            rx_nxt.seen_at_req = tx_r.seen;
          end
        end
      end
    end
    rx_nxt.cs_prev = cs_n;
    if (link_rst) begin
      rx_nxt.state = P_HUNT;
      rx_nxt.bitcnt = 3'h0;
      rx_nxt.cs_prev = 1'b1;
      rx_nxt.seen_at_req = tx_r.seen;
    end
  end

  always_ff @(posedge sclk) begin
    rx_r <= rx_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link falling edge: result shifter
  // The result word and its toggle stay still for the whole readout, and the
  // host only clocks after seeing the strobe high, so reading them here is safe.
  assign fresh = core_r.done_tog != tx_r.seen;

  always_comb begin
    tx_nxt = tx_r;
    if (!cs_n) begin // see R11
      if (fresh) begin
        tx_nxt.seen = core_r.done_tog;
        tx_nxt.cnt = 5'h1;
      end else if (tx_r.cnt < 5'(OUT_BITS)) begin
        tx_nxt.cnt = tx_r.cnt + 5'h1; // see R1
      end
    end
    if (link_rst) begin
      tx_nxt.seen = core_r.done_tog;
      tx_nxt.cnt = 5'(OUT_BITS);
    end
  end

  always_ff @(negedge sclk) begin
    tx_r <= tx_nxt;
  end

  always_comb begin
    if (fresh)
      dout = core_r.result[RES_W-1]; // see R9
    else if (tx_r.cnt < 5'(OUT_BITS))
      dout = core_r.result[4'(15 - tx_r.cnt)]; // see R1
    else
      dout = 1'b0; // see R10
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core clock: configuration and conversion sequencing
  logic             cmd_ev;
  logic [CMD_W-1:0] cmd;
  logic [TMR_W-1:0] load;

  assign cmd_ev = core_r.tog_s2 ^ core_r.tog_d;
  assign cmd = rx_r.cmd_byte;

  always_comb begin
    core_nxt = core_r;
    core_nxt.tog_s1 = rx_r.cmd_tog;
    core_nxt.tog_s2 = core_r.tog_s1;
    core_nxt.tog_d = core_r.tog_s2;
    load = TMR_W'(is_diode(cmd[SEL_HI:0]) ? TEMP_CYC : VOLT_CYC); // see R8
    if (core_r.pm != PM_NORMAL)
      load = load + TMR_W'(WAKE); // see R18 see R19
    if (cmd_ev && is_cfg(cmd)) begin
      core_nxt.pm = cmd[CFG_PM_HI:CFG_PM_LO]; // see R17
      core_nxt.ref_int = cmd[CFG_REF_POS]; // see R16
      if (cmd[CFG_PM_HI:CFG_PM_LO] == PM_SHUTDOWN && !core_r.busy)
        core_nxt.result = '0; // see R20
    end else if (cmd_ev && is_conv(cmd) && !core_r.busy) begin
      core_nxt.sel = cmd[SEL_HI:0]; // see R12
      core_nxt.temp = is_diode(cmd[SEL_HI:0]); // see R26
      core_nxt.busy = 1'b1; // see R6
      core_nxt.timer = load;
    end
    if (core_r.busy) begin // see R11
      if (core_r.timer == TMR_W'(1)) begin
        core_nxt.busy = 1'b0;
        core_nxt.result = fmt(core_r.temp, ana);
        core_nxt.done_tog = ~core_r.done_tog;
      end else begin
        core_nxt.timer = core_r.timer - TMR_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      core_r <= '0; // see R4
    end else begin
      core_r <= core_nxt;
    end
  end

  assign conversion_strobe = ~core_r.busy; // see R6

  always_comb begin
    actl.power_mode = core_r.pm;
    actl.iref_en = core_r.ref_int || (core_r.busy && core_r.temp); // see R16
    actl.ref_buf_en = actl.iref_en &&
                      (core_r.busy || core_r.pm == PM_NORMAL ||
                       core_r.pm == PM_STBY_PLUS); // see R19
    actl.clk_run = core_r.busy || core_r.pm == PM_NORMAL; // see R18
    actl.temp_mode = core_r.busy && core_r.temp;
    actl.input_select = core_r.sel;
    actl.convert_active = core_r.busy;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  int unsigned low_cnt;
  int unsigned exp_cnt;

  always_ff @(posedge clk) begin
    if (rst || !core_r.busy)
      low_cnt <= 0;
    else
      low_cnt <= low_cnt + 1;
    if (cmd_ev && is_conv(cmd) && !is_cfg(cmd) && !core_r.busy)
      exp_cnt <= int'(load);
  end

  a_power_up_off: assert property (@(posedge clk) // see R4
    rst |=> core_r.pm == PM_SHUTDOWN && conversion_strobe)
    else $error("not in shutdown after reset");

  a_cfg_mode_load: assert property (@(posedge clk) disable iff (rst) // see R13
    cmd_ev && is_cfg(cmd) |=> core_r.pm == $past(cmd[CFG_PM_HI:CFG_PM_LO]) &&
      core_r.ref_int == $past(cmd[CFG_REF_POS]))
    else $error("configuration byte not applied");

  a_strobe_fall: assert property (@(posedge clk) disable iff (rst) // see R6
    cmd_ev && is_conv(cmd) && !is_cfg(cmd) && conversion_strobe |=> !conversion_strobe)
    else $error("strobe did not fall on conversion byte");

  a_conv_length: assert property (@(posedge clk) disable iff (rst) // see R8
    $rose(conversion_strobe) |-> low_cnt == exp_cnt && $past(low_cnt) + 1 == exp_cnt)
    else $error("conversion length wrong");

  a_temp_format: assert property (@(posedge clk) disable iff (rst) // see R2
    $rose(conversion_strobe) && core_r.temp |->
      core_r.result == {2'h0, $past(ana.temp_code), 2'h0})
    else $error("temperature word malformed");

  a_volt_format: assert property (@(posedge clk) disable iff (rst) // see R3
    $rose(conversion_strobe) && !core_r.temp |->
      core_r.result[15] == core_r.result[14] && core_r.result[1:0] == 2'h0 &&
      core_r.result[14:5] == $past(ana.volt_code))
    else $error("voltage word malformed");

  a_shut_clear: assert property (@(posedge clk) disable iff (rst) // see R20
    cmd_ev && is_cfg(cmd) && cmd[CFG_PM_HI:CFG_PM_LO] == PM_SHUTDOWN && !core_r.busy
      |=> core_r.result == '0)
    else $error("shutdown did not clear result");

  a_temp_iref: assert property (@(posedge clk) disable iff (rst) // see R16
    actl.temp_mode |-> actl.iref_en && actl.ref_buf_en)
    else $error("temperature without internal reference");

  a_diode_temp: assert property (@(posedge clk) disable iff (rst) // see R26
    cmd_ev && is_conv(cmd) && !is_cfg(cmd) && !core_r.busy |=>
      core_r.temp == is_diode(core_r.sel))
    else $error("conversion kind wrong");

  a_tail_zero: assert property (@(negedge sclk) disable iff (link_rst) // see R10
    tx_r.cnt == 5'(OUT_BITS) && !fresh |-> !dout)
    else $error("nonzero after sixteen bits");

  a_cs_hold: assert property (@(negedge sclk) disable iff (link_rst) // see R11
    cs_n |=> tx_r.cnt == $past(tx_r.cnt))
    else $error("shifted with chip select high");

  c_temp_conv: cover property (@(posedge clk) disable iff (rst)
    $rose(conversion_strobe) && core_r.temp);
  c_volt_conv: cover property (@(posedge clk) disable iff (rst)
    $rose(conversion_strobe) && !core_r.temp);
  c_readout: cover property (@(negedge sclk) disable iff (link_rst)
    tx_r.cnt == 5'(OUT_BITS) && rx_r.state == P_WAIT_OUT);

endmodule : sacs_serial_ctrl
`default_nettype wire

// *** common/sacs_pkg.sv ***
// Constants, field layouts and carrier types of the serial converter control.
// Assumes a 100 MHz core clock; the link clock comes from the host.
`default_nettype none
package sacs_pkg;
  localparam int CMD_W = 8;
  localparam int RES_W = 16;
  localparam int OUT_BITS = 16;
  // Command byte fields
  localparam int CFG_PM_HI = 2;
  localparam int CFG_PM_LO = 1;
  localparam int CFG_REF_POS = 0;
  localparam int CFG_TAG_HI = 6;
  localparam int CFG_TAG_LO = 3;
  localparam int CONV_TAG_HI = 6;
  localparam int CONV_TAG_LO = 4;
  localparam int SEL_HI = 3;
  localparam logic [3:0] CFG_TAG = 4'h0;
  localparam logic [2:0] CONV_TAG = 3'h2;
  // Power modes
  localparam logic [1:0] PM_SHUTDOWN = 2'h0;
  localparam logic [1:0] PM_STBY_PLUS = 2'h1;
  localparam logic [1:0] PM_STBY = 2'h2;
  localparam logic [1:0] PM_NORMAL = 2'h3;
  // Diode input codes
  localparam logic [3:0] SEL_INT_DIODE = 4'h7;
  localparam logic [3:0] SEL_EXT_DIODE1 = 4'hc;
  localparam logic [3:0] SEL_EXT_DIODE2 = 4'hd;
  // Reset values
  localparam logic [1:0] PM_RESET = PM_SHUTDOWN;
  localparam logic REF_RESET = 1'b0;
  localparam logic [3:0] SEL_RESET = 4'h0;
  // Timing
  localparam real CLK_MHZ = 100.0;
  localparam real TEMP_CONV_MS = 2.2;
  localparam real VOLT_CONV_MS = 1.1;
  localparam real WAKE_MS = 0.1;
  localparam int TEMP_CONV_CYC = int'(TEMP_CONV_MS * 1000.0 * CLK_MHZ);
  localparam int VOLT_CONV_CYC = int'(VOLT_CONV_MS * 1000.0 * CLK_MHZ);
  localparam int WAKE_CYC = int'(WAKE_MS * 1000.0 * CLK_MHZ);
  localparam int TMR_W = 20;

  typedef enum logic [1:0] {P_HUNT, P_SHIFT, P_WAIT_OUT} sacs_parse_t;

  typedef struct packed {
    logic [11:0] temp_code;
    logic [9:0]  volt_code;
    logic [2:0]  volt_sub;
  } sacs_ana_t;

  typedef struct packed {
    logic [1:0] power_mode;
    logic       iref_en;
    logic       ref_buf_en;
    logic       clk_run;
    logic       temp_mode;
    logic [3:0] input_select;
    logic       convert_active;
  } sacs_actl_t;

  typedef struct packed {
    logic              rst_s1;
    logic              rst_s2;
    sacs_parse_t       state;
    logic [6:0]        shreg;
    logic [2:0]        bitcnt;
    logic              cs_prev;
    logic [CMD_W-1:0]  cmd_byte;
    logic              cmd_tog;
    logic              seen_at_req;
  } sacs_rx_t;

  typedef struct packed {
    logic       seen;
    logic [4:0] cnt;
  } sacs_tx_t;

  typedef struct packed {
    logic              tog_s1;
    logic              tog_s2;
    logic              tog_d;
    logic [1:0]        pm;
    logic              ref_int;
    logic [3:0]        sel;
    logic              temp;
    logic              busy;
    logic [TMR_W-1:0]  timer;
    logic [RES_W-1:0]  result;
    logic              done_tog;
  } sacs_core_t;
endpackage : sacs_pkg
`default_nettype wire

// *** sim/sacs_host_model.sv ***
// Host side of the four-wire link: master clock, chip select and data in; data out is read.
// Assumes the bench calls its tasks one at a time; the clock rests low between them.
`default_nettype none
module sacs_host_model (
  // Link to the device
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam time HALF = 16ns;
  ////////////////////////////////////////////////////////////
  // Clock stays still outside tasks, so it is quiet while converting
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end
  // Data out is taken at the rising edge, mid-way through its bit
  task automatic pulse(output logic s);
    #HALF sclk = 1'b1;
    s = dout;
    #HALF sclk = 1'b0;
  endtask : pulse
  task automatic idle(input int n);
    logic s;
    repeat (n) pulse(s);
  endtask : idle
  // Select moves away from the falling edge to keep the device free of races
  task automatic hold(input int n);
    #4 cs_n = 1'b1;
    idle(n);
    #4 cs_n = 1'b0;
  endtask : hold
  task automatic frame();
    hold(1);
  endtask : frame
  task automatic send(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      din = b[i];
      pulse(s);
    end
    // Data returns low off the edge, so a following byte never sets it twice at once
    #2 din = 1'b0;
    #2;
  endtask : send
  task automatic read(input int n, inout logic [31:0] w);
    logic s;
    repeat (n) begin
      pulse(s);
      w = {w[30:0], s};
    end
  endtask : read
endmodule : sacs_host_model
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench of the serial converter control, driven through a host model.
// Assumes shortened conversion counts so the run stays brief.
`default_nettype none
module tb
  import sacs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 20;
  localparam int VC = 10;
  localparam int WK = 5;
  typedef struct packed {
    logic [7:0] cfg;
    logic [3:0] sel;
  } sacs_row_t;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sclk, cs_n, din, dout, conversion_strobe;
  sacs_ana_t   ana = '0;
  sacs_actl_t  actl;
  int          fails = 0;
  int          total_checks = 0;
  logic [1:0]  pm_e = PM_SHUTDOWN;
  logic        ref_e = 1'b0;
  logic [31:0] w;
  int          n;
  // Config 8'h00 means the conversion byte goes alone
  sacs_row_t   rows [7] = '{'{8'h00, 4'h8}, '{8'h87, 4'h7}, '{8'h00, 4'h0},
    '{8'h84, 4'hc}, '{8'h83, 4'hb}, '{8'h86, 4'hd}, '{8'h00, 4'h5}};
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////
  sacs_serial_ctrl #(.TEMP_CYC(TC), .VOLT_CYC(VC), .WAKE(WK)) u_sacs_serial_ctrl (
    .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .conversion_strobe(conversion_strobe), .ana(ana), .actl(actl));
  sacs_host_model u_sacs_host_model (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
  ////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [17:0] e, input logic [17:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic chk_cnt(input string what, input int e, input int g);
    total_checks++;
    if (g != e) begin
      fails++;
      $display("Error %s expected %0d seen %0d", what, e, g);
    end
  endtask : chk_cnt
  task automatic wait_sb(input logic lvl, input int lim, output int k);
    k = 0;
    while (conversion_strobe !== lvl) begin
      @(negedge clk);
      k++;
      if (k > lim) begin
        chk("strobe wait", 18'(lvl), 18'(conversion_strobe));
        complete_run();
      end
    end
  endtask : wait_sb
  task automatic run_conv(input sacs_row_t r, input bit rd);
    logic        t;
    logic [17:0] exp;
    t = (r.sel == SEL_INT_DIODE) || (r.sel == SEL_EXT_DIODE1) || (r.sel == SEL_EXT_DIODE2);
    exp = t ? {2'h0, ana.temp_code, 4'h0}
            : {ana.volt_code[9], ana.volt_code, ana.volt_sub, 4'h0};
    if (r.cfg != 8'h00) begin
      u_sacs_host_model.send(r.cfg);
      pm_e = r.cfg[2:1];
      ref_e = r.cfg[0];
    end
    u_sacs_host_model.send({4'ha, r.sel});
    wait_sb(1'b0, 20, n);
    chk("actl", 18'({pm_e, t | ref_e, t | ref_e, 1'b1, t, r.sel, 1'b1}), 18'(actl));
    wait_sb(1'b1, 400, n);
    chk_cnt("conv cycles", (t ? TC : VC) + (pm_e != PM_NORMAL ? WK : 0), n);
    chk("actl idle", 18'({pm_e, ref_e, ref_e && (pm_e == PM_NORMAL || pm_e == PM_STBY_PLUS),
        pm_e == PM_NORMAL, 1'b0, r.sel, 1'b0}), 18'(actl));
    if (rd) begin
      w = '0;
      u_sacs_host_model.read(4, w);
      u_sacs_host_model.hold(2);
      u_sacs_host_model.read(14, w);
      chk("word", exp, w[17:0]);
    end
    $display("conversion sel %h done", r.sel);
  endtask : run_conv
  ////////////////////////////////////////////////////////////
  initial begin
    fork
      u_sacs_host_model.idle(4);
      repeat (16) @(negedge clk);
    join
    chk("reset", 18'h1000, 18'({conversion_strobe, actl, dout}));
    rst = 1'b0;
    repeat (3) @(negedge clk);
    // The link side clears its own reset only after two link clocks
    u_sacs_host_model.idle(3);
    $display("reset test done");
    for (int i = 0; i < 7; i++) begin
      @(negedge clk);
      ana.temp_code = 12'h5a3 + 12'(i);
      ana.volt_code = 10'h2c5 ^ 10'(i);
      ana.volt_sub  = 3'h5 - 3'(i);
      u_sacs_host_model.frame();
      run_conv(rows[i], 1'b1);
    end
    u_sacs_host_model.frame();
    u_sacs_host_model.send(8'hb3);
    u_sacs_host_model.send(8'h88);
    repeat (40) begin
      @(negedge clk);
      chk("idle strobe", 18'h1, 18'(conversion_strobe));
    end
    chk("mode kept", 18'(pm_e), 18'(actl.power_mode));
    $display("unknown byte test done");
    run_conv('{8'h00, 4'h1}, 1'b1);
    u_sacs_host_model.frame();
    run_conv('{8'h00, 4'h0}, 1'b0);
    u_sacs_host_model.frame();
    u_sacs_host_model.send(8'h80);
    repeat (10) @(negedge clk);
    chk("shutdown mode", 18'(PM_SHUTDOWN), 18'(actl.power_mode));
    w = '0;
    u_sacs_host_model.read(18, w);
    chk("cleared word", 18'h0, w[17:0]);
    $display("shutdown test done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
